// >>> ffse_engine.sv
// Operation
// - before each write burst wait until tx level bits [15:5] are nonzero
// - each write burst holds tx pop high exactly 32 consecutive cycles
// - after 32nd pop drop pop; recheck level if data remains, else idle
// - move file count times file size/16 words per write or read; the code moves 32 words per unit of file size
// - on read request raise in-progress flag and start with given index, count
// - busy falls only after all read data forwarded; total unchanged by reads
// - rx push only in cycles where the 128-bit word is valid
// - before each read burst wait until rx fill bits [15:6] are not 1023
// - each read burst holds rx push high 32 consecutive cycles
// - after read burst drop push; recheck rx space and received drive data
// - raise error flag on own or nvme error; report cause on 32-bit detail
// - error flag stays set until active-low reset
// - files grouped into folders of files_per_folder consecutive indexes
// - lower write index overwrites; total never decreases except by format
// - one file size for all files, set only by format
// - command codes 00 format, 01 shutdown, 10 write, 11 read
// - write completion raises total to first index plus count when that is larger
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module ffse_engine
	import ffse_pkg::*;
(
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rstn,
	// apb slave
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// user command
	input  wire logic [1:0]         command_code,
	input  wire logic [FILE_W-1:0]  first_file_index,
	input  wire logic [FILE_W-1:0]  file_count,
	input  wire logic               command_request,
	output logic                    operation_in_progress,
	output logic [FILE_W-1:0]       stored_file_total,
	output logic [SIZE_W-1:0]       stored_file_size,
	output logic [FILE_W-1:0]       files_per_folder,
	output logic [FILE_W-1:0]       current_folder,
	output logic                    error_flag_out,
	output logic [31:0]             error_detail_code,
	// user transmit fifo
	input  wire logic [FILL_W-1:0]  tx_fifo_level,
	output logic                    tx_fifo_pop,
	input  wire logic [WORD_W-1:0]  tx_fifo_word,
	// user receive fifo
	input  wire logic [FILL_W-1:0]  rx_fifo_fill,
	output logic                    rx_fifo_push,
	output logic [WORD_W-1:0]       rx_fifo_word,
	// nvme write data
	output logic                    nvme_wr_valid,
	output logic [WORD_W-1:0]       nvme_wr_word,
	// nvme read data, word valid one cycle after pop
	input  wire logic [FILL_W-1:0]  nvme_rx_count,
	output logic                    nvme_rx_pop,
	input  wire logic [WORD_W-1:0]  nvme_rx_word,
	// nvme status
	input  wire logic               nvme_error,
	input  wire logic [31:0]        nvme_error_type
);

	ffse_state_t state;
	ffse_state_t next_state;

	logic [SHIFT_W-1:0] folder_shift;
	logic [SIZE_W-1:0]  fsize_setting;
	logic [FILE_W-1:0]  cmd_index;
	logic [FILE_W-1:0]  cmd_count;
	logic [FILE_W-1:0]  cur_file;
	logic [FILE_W-1:0]  files_left;
	logic [SIZE_W-1:0]  blocks_left;
	logic [31:0]        bursts_moved;
	logic [DRAIN_W-1:0] drain_cnt;
	logic               cmd_is_write;
	logic               pop_d;
	logic               rpop_d;
	logic               burst_start;
	logic               burst_sel;
	logic               burst_done;
	logic [1:0]         strobe;
	logic [FILE_W:0]    req_end;
	logic [FILE_W:0]    cmd_end;
	logic               take_cmd;
	logic               tx_ready;
	logic               rx_ready;
	logic               read_bad;
	logic               write_bad;
	logic               apb_access;
	logic               apb_commit;

	assign take_cmd  = (state == ST_IDLE) && command_request;
	assign req_end   = {1'b0, first_file_index} + {1'b0, file_count};
	assign cmd_end   = {1'b0, cmd_index} + {1'b0, cmd_count};
	assign read_bad  = req_end > {1'b0, stored_file_total};
	assign write_bad = first_file_index > stored_file_total;
	assign tx_ready  = tx_fifo_level[FILL_W-1:TX_LVL_LSB] != '0;
	// received drive data must cover a full burst as well as fifo room
	assign rx_ready  = (rx_fifo_fill[FILL_W-1:RX_FILL_LSB] != RX_FILL_FULL) &&
	                   (nvme_rx_count[FILL_W-1:NV_CNT_LSB] != '0);
	assign burst_start = (state == ST_WCHK && tx_ready) || (state == ST_RCHK && rx_ready);
	assign burst_sel   = (state == ST_RCHK);

	ffse_burst #(
		.LEN (BURST_WORDS),
		.CW  (BURST_CNT_W)
	) u_burst (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.start   (burst_start),
		.sel     (burst_sel),
		.strobe  (strobe),
		.done    (burst_done)
	);

	assign tx_fifo_pop = strobe[0];
	assign nvme_rx_pop = strobe[1];

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take_cmd) begin
					case (command_code)
						CMD_FORMAT:   next_state = ST_FORMAT;
						CMD_SHUTDOWN: next_state = ST_SHUTDOWN;
						CMD_WRITE: begin
							if (file_count == '0 || stored_file_size == '0)
								next_state = ST_FINISH;
							else
								next_state = ST_WCHK;
						end
						default: begin
							// an out of range read moves no data at all
							if (read_bad || file_count == '0 || stored_file_size == '0)
								next_state = ST_FINISH;
							else
								next_state = ST_RCHK;
						end
					endcase
				end
			end
			ST_FORMAT:   next_state = ST_FINISH;
			ST_SHUTDOWN: next_state = ST_FINISH;
			ST_WCHK: begin
				if (tx_ready)
					next_state = ST_WBURST;
			end
			ST_WBURST: begin
				if (burst_done)
					next_state = (files_left != '0) ? ST_WCHK : ST_DRAIN;
			end
			ST_RCHK: begin
				if (rx_ready)
					next_state = ST_RBURST;
			end
			ST_RBURST: begin
				if (burst_done)
					next_state = (files_left != '0) ? ST_RCHK : ST_DRAIN;
			end
			ST_DRAIN: begin
				if (drain_cnt == DRAIN_W'(DRAIN_CYC - 1))
					next_state = ST_FINISH;
			end
			ST_FINISH:   next_state = ST_IDLE;
			default:     next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			operation_in_progress <= 1'b0;
		end else if (take_cmd) begin
			operation_in_progress <= 1'b1;
		end else if (state == ST_FINISH) begin
			operation_in_progress <= 1'b0;
		end
	end

	// latch command inputs once, at acceptance
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_index    <= '0;
			cmd_count    <= '0;
			cmd_is_write <= 1'b0;
		end else if (take_cmd) begin
			cmd_index    <= first_file_index;
			cmd_count    <= file_count;
			cmd_is_write <= (command_code == CMD_WRITE);
		end
	end

	// each burst is one 512-byte block; a file is stored_file_size blocks
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cur_file    <= '0;
			files_left  <= '0;
			blocks_left <= '0;
		end else if (take_cmd) begin
			cur_file    <= first_file_index;
			files_left  <= file_count;
			blocks_left <= stored_file_size;
		end else if (burst_start) begin
			if (blocks_left == SIZE_W'(1)) begin
				blocks_left <= stored_file_size;
				files_left  <= files_left - 1'b1;
				cur_file    <= cur_file + 1'b1;
			end else begin
				blocks_left <= blocks_left - 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			bursts_moved <= '0;
		else if (take_cmd)
			bursts_moved <= '0;
		else if (burst_done)
			bursts_moved <= bursts_moved + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			drain_cnt <= '0;
		else if (state == ST_DRAIN)
			drain_cnt <= drain_cnt + 1'b1;
		else
			drain_cnt <= '0;
	end

	// write path: word arrives a cycle after pop, forwarded a cycle later
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pop_d         <= 1'b0;
			nvme_wr_valid <= 1'b0;
			nvme_wr_word  <= '0;
		end else begin
			pop_d         <= tx_fifo_pop;
			nvme_wr_valid <= pop_d;
			nvme_wr_word  <= tx_fifo_word;
		end
	end

	// read path: drive word lags its pop by one cycle, so push lags by two
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rpop_d       <= 1'b0;
			rx_fifo_push <= 1'b0;
			rx_fifo_word <= '0;
		end else begin
			rpop_d       <= nvme_rx_pop;
			rx_fifo_push <= rpop_d;
			rx_fifo_word <= nvme_rx_word;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stored_file_total <= '0;
			stored_file_size  <= '0;
		end else if (state == ST_FORMAT) begin
			stored_file_total <= '0;
			stored_file_size  <= fsize_setting;
		end else if (state == ST_FINISH && cmd_is_write) begin
			// overwrite below the total never shrinks it
			if (cmd_end > {1'b0, stored_file_total})
				stored_file_total <= cmd_end[FILE_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			files_per_folder <= '0;
			current_folder   <= '0;
		end else begin
			files_per_folder <= FILE_W'(1) << folder_shift;
			current_folder   <= cur_file >> folder_shift;
		end
	end

	// sticky, only reset clears it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			error_flag_out    <= 1'b0;
			error_detail_code <= '0;
		end else begin
			if (nvme_error) begin
				error_flag_out    <= 1'b1;
				error_detail_code <= error_detail_code | nvme_error_type;
			end
			if (take_cmd && command_code == CMD_WRITE && write_bad) begin
				error_flag_out                  <= 1'b1;
				error_detail_code[ERR_WR_INDEX] <= 1'b1;
			end
			if (take_cmd && command_code == CMD_READ && read_bad) begin
				error_flag_out                  <= 1'b1;
				error_detail_code[ERR_RD_RANGE] <= 1'b1;
			end
			if (take_cmd && command_code[1] && stored_file_size == '0) begin
				error_flag_out                  <= 1'b1;
				error_detail_code[ERR_ZERO_LEN] <= 1'b1;
			end
		end
	end

	// apb: one wait state, answer on the second access cycle
	assign apb_access = psel && penable;
	assign apb_commit = apb_access && pready;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			pready <= 1'b0;
		else
			pready <= apb_access && !pready;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (apb_access && !pready) begin
			pslverr <= 1'b0;
			prdata  <= '0;
			case (paddr)
				OFF_CTRL:    prdata <= 32'(folder_shift);
				OFF_FSIZE:   prdata <= 32'(fsize_setting);
				OFF_STATUS: begin
					prdata[ST_BUSY_BIT] <= operation_in_progress;
					prdata[ST_ERR_BIT]  <= error_flag_out;
					prdata[ST_STATE_LSB +: 4] <= state;
				end
				OFF_TOTAL:   prdata <= 32'(stored_file_total);
				OFF_ERR:     prdata <= error_detail_code;
				OFF_CURFILE: prdata <= 32'(cur_file);
				OFF_BURSTS:  prdata <= bursts_moved;
				default:     pslverr <= 1'b1;
			endcase
		end else begin
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			folder_shift  <= RST_SHIFT;
			fsize_setting <= RST_FSIZE;
		end else if (apb_commit && pwrite) begin
			case (paddr)
				OFF_CTRL:  folder_shift  <= pwdata[SHIFT_W-1:0];
				OFF_FSIZE: fsize_setting <= pwdata[SIZE_W-1:0];
				default:   ;
			endcase
		end
	end

endmodule

// >>> ffse_pkg.sv
package ffse_pkg;

	// data path
	localparam int WORD_W        = 128;
	localparam int FILL_W        = 16;
	localparam int BURST_WORDS   = 32;
	localparam int BURST_CNT_W   = 5;
	localparam int TX_LVL_LSB    = 5;
	localparam int RX_FILL_LSB   = 6;
	localparam int NV_CNT_LSB    = 5;
	localparam logic [9:0] RX_FILL_FULL = 10'h3FF;
	localparam int DRAIN_CYC     = 2;
	localparam int DRAIN_W       = 2;

	// file bookkeeping
	localparam int FILE_W        = 32;
	localparam int SHIFT_W       = 4;
	localparam int SIZE_W        = 32;

	// command codes
	localparam logic [1:0] CMD_FORMAT   = 2'h0;
	localparam logic [1:0] CMD_SHUTDOWN = 2'h1;
	localparam logic [1:0] CMD_WRITE    = 2'h2;
	localparam logic [1:0] CMD_READ     = 2'h3;

	// apb map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_FSIZE   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_TOTAL   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_ERR     = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CURFILE = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_BURSTS  = 8'h18;

	// reset values
	localparam logic [SHIFT_W-1:0] RST_SHIFT = 4'h9;
	localparam logic [SIZE_W-1:0]  RST_FSIZE = 32'h0001_0000;

	// status and error bit positions
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_ERR_BIT   = 1;
	localparam int ST_STATE_LSB = 4;
	localparam int ERR_WR_INDEX = 0;
	localparam int ERR_RD_RANGE = 1;
	localparam int ERR_ZERO_LEN = 2;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_FORMAT,
		ST_SHUTDOWN,
		ST_WCHK,
		ST_WBURST,
		ST_RCHK,
		ST_RBURST,
		ST_DRAIN,
		ST_FINISH
	} ffse_state_t;

endpackage

// >>> ffse_burst.sv
`timescale 1ns/1ps
module ffse_burst
	import ffse_pkg::*;
#(
	parameter int LEN = BURST_WORDS,
	parameter int CW  = BURST_CNT_W
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	// control
	input  wire logic       start,
	input  wire logic       sel,
	// strobes, one per direction
	output logic [1:0]      strobe,
	output logic            done
);

	logic [CW-1:0] cnt;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			strobe <= 2'h0;
			cnt    <= '0;
		end else if (strobe == 2'h0) begin
			if (start) begin
				strobe[sel] <= 1'b1;
				cnt         <= '0;
			end
		end else if (cnt == CW'(LEN - 1)) begin
			strobe <= 2'h0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			done <= 1'b0;
		end else begin
			done <= (strobe != 2'h0) && (cnt == CW'(LEN - 1));
		end
	end

endmodule

// >>> ffse_partner.sv
`timescale 1ns/1ps
module ffse_partner
	import ffse_pkg::*;
(
	// clock, reset and stall control
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic              tx_ok,
	input  wire logic              rx_ok,
	// transmit fifo
	input  wire logic              tx_fifo_pop,
	output logic [FILL_W-1:0]      tx_fifo_level,
	output logic [WORD_W-1:0]      tx_fifo_word,
	// receive fifo and drive
	input  wire logic              nvme_rx_pop,
	output logic [FILL_W-1:0]      rx_fifo_fill,
	output logic [FILL_W-1:0]      nvme_rx_count,
	output logic [WORD_W-1:0]      nvme_rx_word
);
	logic [31:0] tseq;
	logic [31:0] rseq;
	// stalled level sits one word short of a burst
	assign tx_fifo_level = tx_ok ? 16'h0020 : 16'h001F;
	assign rx_fifo_fill  = rx_ok ? 16'h0000 : 16'hFFC0;
	assign nvme_rx_count = rx_ok ? 16'h0020 : 16'h0000;
	// idle words toggle so a stale sample never matches
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tseq         <= '0;
			rseq         <= '0;
			tx_fifo_word <= '0;
			nvme_rx_word <= '0;
		end else begin
			tx_fifo_word <= tx_fifo_pop ? {4{tseq}} : ~tx_fifo_word;
			tseq         <= tseq + {31'h0, tx_fifo_pop};
			nvme_rx_word <= nvme_rx_pop ? {4{rseq}} : ~nvme_rx_word;
			rseq         <= rseq + {31'h0, nvme_rx_pop};
		end
	end
endmodule

// >>> ffse_checker.sv
`timescale 1ns/1ps
module ffse_checker
	import ffse_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	// watched ports
	input  wire logic              command_request,
	input  wire logic              operation_in_progress,
	input  wire logic [FILE_W-1:0] stored_file_total,
	input  wire logic [FILE_W-1:0] files_per_folder,
	input  wire logic              error_flag_out,
	input  wire logic [FILL_W-1:0] tx_fifo_level,
	input  wire logic              tx_fifo_pop,
	input  wire logic [FILL_W-1:0] rx_fifo_fill,
	input  wire logic              rx_fifo_push,
	input  wire logic              nvme_wr_valid,
	input  wire logic              nvme_rx_pop
);
	logic [5:0] pop_run;
	logic [5:0] push_run;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// run lengths, judged on the falling edge of each strobe
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pop_run  <= '0;
			push_run <= '0;
		end else begin
			pop_run  <= tx_fifo_pop ? pop_run + 6'h01 : 6'h00;
			push_run <= rx_fifo_push ? push_run + 6'h01 : 6'h00;
		end
	end
	pop_len_a: assert property ($fell(tx_fifo_pop) |-> pop_run == 6'h20)
		else $error("tx pop run not 32");
	pop_gate_a: assert property ($rose(tx_fifo_pop) |-> $past(tx_fifo_level[15:5]) != 11'h000)
		else $error("tx burst without level");
	push_len_a: assert property ($fell(rx_fifo_push) |-> push_run == 6'h20)
		else $error("rx push run not 32");
	push_gate_a: assert property ($rose(nvme_rx_pop) |-> $past(rx_fifo_fill[15:6]) != RX_FILL_FULL)
		else $error("rx burst without room");
	push_valid_a: assert property (rx_fifo_push |-> $past(nvme_rx_pop, 2))
		else $error("push without word");
	fwd_word_a: assert property (tx_fifo_pop |-> ##2 nvme_wr_valid)
		else $error("popped word not forwarded");
	cmd_take_a: assert property (command_request && !operation_in_progress |=> operation_in_progress)
		else $error("request not taken");
	total_hold_a: assert property (operation_in_progress && $past(operation_in_progress) |-> $stable(stored_file_total))
		else $error("total moved while busy");
	err_sticky_a: assert property (error_flag_out |=> error_flag_out)
		else $error("error flag dropped");
	folder_pow_a: assert property (files_per_folder != '0 |-> $onehot(files_per_folder))
		else $error("folder size not power of two");
endmodule

bind ffse_engine ffse_checker ffse_checker_inst (
	.sys_clk, .rstn, .command_request, .operation_in_progress, .stored_file_total,
	.files_per_folder, .error_flag_out, .tx_fifo_level, .tx_fifo_pop, .rx_fifo_fill,
	.rx_fifo_push, .nvme_wr_valid, .nvme_rx_pop
);

// >>> testbench.sv
`timescale 1ns/1ps
module testbench
	import ffse_pkg::*;
;
	logic              sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata, error_detail_code, nvme_error_type = '0, rd;
	logic [1:0]        command_code = '0, ok = '0;
	logic [FILE_W-1:0] first_file_index = '0, file_count = '0, stored_file_total, files_per_folder, current_folder;
	logic              command_request = 1'b0, nvme_error = 1'b0, er;
	logic              pready, pslverr, operation_in_progress, error_flag_out;
	logic              tx_fifo_pop, rx_fifo_push, nvme_wr_valid, nvme_rx_pop;
	logic [SIZE_W-1:0] stored_file_size;
	logic [FILL_W-1:0] tx_fifo_level, rx_fifo_fill, nvme_rx_count;
	logic [WORD_W-1:0] tx_fifo_word, rx_fifo_word, nvme_wr_word, nvme_rx_word;
	int                error_cnt = 0, n_compared = 0, tx_k = 0, rx_k = 0, tot = 0, sh;
	int                seed = 32'h8836;

	always #50 sys_clk = ~sys_clk;

	ffse_engine ffse_engine_inst (
		.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.command_code, .first_file_index, .file_count, .command_request, .operation_in_progress,
		.stored_file_total, .stored_file_size, .files_per_folder, .current_folder,
		.error_flag_out, .error_detail_code, .tx_fifo_level, .tx_fifo_pop, .tx_fifo_word,
		.rx_fifo_fill, .rx_fifo_push, .rx_fifo_word, .nvme_wr_valid, .nvme_wr_word,
		.nvme_rx_count, .nvme_rx_pop, .nvme_rx_word, .nvme_error, .nvme_error_type
	);
	ffse_partner ffse_partner_inst (
		.sys_clk, .rstn, .tx_ok(ok[0]), .rx_ok(ok[1]), .tx_fifo_pop, .tx_fifo_level,
		.tx_fifo_word, .nvme_rx_pop, .rx_fifo_fill, .nvme_rx_count, .nvme_rx_word
	);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t value %h expected %h", $time, g, e);
		end
	endtask

	task automatic chkw(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t word %h expected %h", $time, g, e);
		end
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// only the watchdog ends a wait for pready
	task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (operation_in_progress !== v && n < 5000);
		chk({31'h0, operation_in_progress}, {31'h0, v});
	endtask

	task automatic cmd(input logic [1:0] c, input int idx, input int cnt);
		command_code <= c;
		first_file_index <= idx;
		file_count <= cnt;
		command_request <= 1'b1;
		wait_busy(1'b1);
		command_request <= 1'b0;
		wait_busy(1'b0);
		if (c == CMD_FORMAT)
			tot = 0;
		else if (c == CMD_WRITE && idx + cnt > tot)
			tot = idx + cnt;
		chk(stored_file_total, tot);
	endtask

	// lets a burst start, starves it after, then frees it again
	task automatic stall(input int i);
		repeat (5 + ($random(seed) & 15)) @(posedge sys_clk);
		ok[i] <= 1'b1;
		repeat (20) @(posedge sys_clk);
		ok[i] <= 1'b0;
		repeat (20) @(posedge sys_clk);
		ok[i] <= 1'b1;
	endtask

	always @(posedge sys_clk) begin
		if (rx_fifo_push === 1'b1) begin
			chkw(rx_fifo_word, {4{rx_k[31:0]}});
			rx_k++;
		end
		if (nvme_wr_valid === 1'b1) begin
			chkw(nvme_wr_word, {4{tx_k[31:0]}});
			tx_k++;
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		apb(OFF_CTRL, 1'b0, '0);
		chk(rd, 32'h0000_0009);
		chk(files_per_folder, 32'h0000_0200);
		sh = $random(seed) & 7;
		apb(OFF_CTRL, 1'b1, sh);
		// folder size is registered from the shift, one edge after the write
		@(posedge sys_clk);
		chk(files_per_folder, 32'h0000_0001 << sh);
		apb(8'h1C, 1'b1, 32'h0000_00FF);
		chk({rd[30:0], er}, 32'h0000_0001);
		apb(OFF_FSIZE, 1'b1, 32'h0000_0001);
		$display("register test done");
		cmd(CMD_FORMAT, 0, 0);
		chk(stored_file_size, 32'h0000_0001);
		fork
			cmd(CMD_WRITE, 0, 2);
			stall(0);
		join
		chk(tx_k, 64);
		fork
			cmd(CMD_READ, 0, 2);
			stall(1);
		join
		chk(rx_k, 64);
		cmd(CMD_WRITE, 0, 1);
		chk(tx_k, 96);
		$display("data test done");
		cmd(CMD_SHUTDOWN, 0, 0);
		cmd(CMD_WRITE, 4, 0);
		chk({error_flag_out, error_detail_code[ERR_WR_INDEX]}, 2'b11);
		chk(current_folder, 4 / (1 << sh));
		nvme_error <= 1'b1;
		nvme_error_type <= 32'h0000_0100;
		@(posedge sys_clk);
		nvme_error <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk({error_flag_out, error_detail_code[8]}, 2'b11);
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({31'h0, error_flag_out}, 32'h0000_0000);
		chk(stored_file_total, 32'h0000_0000);
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(files_per_folder, 32'h0000_0200);
		$display("error test done");
		wrap_up;
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		wrap_up;
	end
endmodule
